// ### pkg/ebm_defines.vh
// constants for the external bus pin muxing block
// assumes inclusion by bare name from verilog/ design files
`ifndef EBM_DEFINES_VH
`define EBM_DEFINES_VH
// bus cycle sequencer states
`define EBM_ST_IDLE 2'h0
`define EBM_ST_ADDR 2'h1
`define EBM_ST_DATA 2'h2
`define EBM_ST_END 2'h3
// byte lane select codes from the core: bit1 high lane, bit0 low lane
`define EBM_LANE_BOTH 2'h3
`define EBM_LANE_HIGH 2'h2
`define EBM_LANE_LOW 2'h1
// phase lengths in clock cycles
`define EBM_ADDR_CYCLES 4'h1
`define EBM_DATA_CYCLES 4'h2
`endif

// ### test/ebm_bus_pins_assertions.sv
// checker for the bus pin sequencer
// assumes bind onto ebm_bus_pins
`timescale 1ns/100ps
`default_nettype none
module ebm_bus_pins_assertions (
   input wire sys_clk,
   input wire rstn,
   input wire busWide,
   input wire busMuxed,
   input wire [15:0] portOut,
   input wire [7:0] sharedUpperOut,
   input wire [7:0] sharedLowerOut,
   input wire [3:0] upperAddrOut_q,
   input wire [15:0] lowAddrOut_q,
   input wire addrLatchStrobe_q,
   input wire highByteEnable_n_q,
   input wire busActive_q,
   input wire done_q
);
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // strobe pulse and its place in the cycle
   AST_STB_PULSE: assert property ($rose(addrLatchStrobe_q) |=> !addrLatchStrobe_q)
      else $error("strobe too long");
   AST_STB_EXT: assert property (addrLatchStrobe_q |-> busActive_q && !done_q)
      else $error("strobe outside cycle");
   AST_STB_DONE: assert property ($rose(addrLatchStrobe_q) |-> ##[1:3] done_q)
      else $error("cycle did not end");
   // address on the shared lines and the address pins
   AST_MUX16: assert property (addrLatchStrobe_q && busMuxed && busWide
      |-> {sharedUpperOut, sharedLowerOut} == lowAddrOut_q)
      else $error("mux address wrong");
   AST_MUX8: assert property (busActive_q && busMuxed && !busWide
      |-> sharedUpperOut == lowAddrOut_q[15:8])
      else $error("upper lines lost address");
   AST_HOLD: assert property (busActive_q && $past(busActive_q)
      |-> $stable(lowAddrOut_q) && $stable(upperAddrOut_q))
      else $error("address moved");
   // high enable only in wide cycles
   AST_HBE8: assert property (!busWide && $past(!busWide) |-> highByteEnable_n_q)
      else $error("high enable in 8-bit");
   AST_HBEIDLE: assert property (!busActive_q |-> highByteEnable_n_q)
      else $error("high enable idle");
   // port function back once idle
   AST_PORT: assert property (!busActive_q && $past(!busActive_q) && $past(rstn)
      && $stable(portOut) |-> sharedLowerOut == portOut[7:0])
      else $error("port not restored");
endmodule // ebm_bus_pins_assertions
bind ebm_bus_pins ebm_bus_pins_assertions chk (.sys_clk(sys_clk), .rstn(rstn),
   .busWide(busWide), .busMuxed(busMuxed), .portOut(portOut),
   .sharedUpperOut(sharedUpperOut), .sharedLowerOut(sharedLowerOut),
   .upperAddrOut_q(upperAddrOut_q), .lowAddrOut_q(lowAddrOut_q),
   .addrLatchStrobe_q(addrLatchStrobe_q), .highByteEnable_n_q(highByteEnable_n_q),
   .busActive_q(busActive_q), .done_q(done_q));
`default_nettype wire

// ### test/ebm_bus_pins_test.sv
// self-checking bench for the bus pin sequencer
// assumes the memory model on the far side and the bound checker
`timescale 1ns/100ps
`default_nettype none
module ebm_bus_pins_test;
   logic sys_clk = 1'b0, rstn = 1'b0, reqValid = 1'b0, reqWrite = 1'b0;
   logic busWide = 1'b1, busMuxed = 1'b1, cfgHbe = 1'b1, seenLow;
   logic [19:0] reqAddr = 20'h00000;
   logic [1:0] reqLanes = 2'h3;
   logic [15:0] reqWdata = 16'h0000, portOut = 16'h5a3c;
   wire [7:0] upOut, loOut;
   wire [3:0] upAddr;
   wire [15:0] loAddr, rdData, level;
   wire upOe, loOe, stb, hbeN, active, done;
   int err_total = 0, num_checks = 0;
   // rows: wide, muxed, lanes, address, data
   logic [39:0] rows [0:5] = '{40'hf9a2c4beef, 40'hb512361357, 40'he30009a500,
      40'h97000a00c3, 40'h54bc0c0011, 40'h1e3f0e0022};
   ebm_bus_pins dut (.sys_clk(sys_clk), .rstn(rstn), .reqValid(reqValid),
      .reqWrite(reqWrite), .reqAddr(reqAddr), .reqLanes(reqLanes), .reqWdata(reqWdata),
      .busWide(busWide), .busMuxed(busMuxed), .chipCfgHighEnable(cfgHbe),
      .internalBus(16'h6e00), .portOut(portOut), .portOe(16'hffff), .sharedIn(level),
      .sharedUpperOut(upOut), .sharedUpperOe(upOe), .sharedLowerOut(loOut),
      .sharedLowerOe(loOe), .upperAddrOut_q(upAddr), .lowAddrOut_q(loAddr),
      .addrLatchStrobe_q(stb), .highByteEnable_n_q(hbeN), .busActive_q(active),
      .rdData_q(rdData), .done_q(done));
   ebm_mem_model far (.sys_clk(sys_clk), .busMuxed(busMuxed), .upOut(upOut),
      .upOe(upOe), .loOut(loOut), .loOe(loOe), .lowAddr(loAddr), .strobe(stb),
      .hbeN(hbeN), .active(active), .level(level));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task results;
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // one held request, pins checked at the strobe, data at done
   task cyc(input logic w, input logic [39:0] r);
      int n;
      logic [15:0] m;
      m = r[39] ? {{8{r[37]}}, {8{r[36]}}} : 16'h00ff;
      n = 0;
      seenLow = 1'b0;
      {busWide, busMuxed, reqLanes, reqAddr, reqWdata} = r;
      reqWrite = w;
      reqValid = 1'b1;
      while (done !== 1'b1 && n < 20) begin
         @(posedge sys_clk);
         #1;
         n++;
         if (hbeN === 1'b0) seenLow = 1'b1;
         if (stb === 1'b1) begin
            chk({12'h000, upAddr}, {12'h000, r[35:32]}, "upa");
            chk(loAddr, r[31:16], "loa");
            if (!r[39]) chk({8'h00, upOut}, {8'h00, r[38] ? r[31:24] : 8'h6e}, "up");
         end
      end
      chk({15'h0000, n < 20}, 16'h0001, "no done");
      if (!w) chk(rdData & m, r[15:0] & m, "rd");
      chk({15'h0000, seenLow}, {15'h0000, r[39] && r[37] && (cfgHbe || w)}, "hbe");
      reqValid = 1'b0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      #1;
      chk({12'h000, hbeN, stb, active, done}, 16'h0008, "reset");
      rstn = 1'b1;
      foreach (rows[i]) begin
         cyc(1'b1, rows[i]);
         cyc(1'b0, rows[i]);
      end
      chk({upOut, loOut}, portOut, "port");
      chk({14'h0000, upOe, loOe}, 16'h0003, "port oe");
      cfgHbe = 1'b0;
      cyc(1'b1, rows[0]);
      cyc(1'b0, rows[0]);
      results();
   end
   // watchdog against a hung request
   initial begin
      #100000;
      err_total++;
      results();
   end
endmodule // ebm_bus_pins_test
`default_nettype wire

// ### test/ebm_mem_model.sv
// external memory and address latch on the shared lines
// assumes one address cycle marked by the strobe
`timescale 1ns/100ps
`default_nettype none
module ebm_mem_model (
   input wire sys_clk,
   input wire busMuxed,
   input wire [7:0] upOut,
   input wire upOe,
   input wire [7:0] loOut,
   input wire loOe,
   input wire [15:0] lowAddr,
   input wire strobe,
   input wire hbeN,
   input wire active,
   output wire [15:0] level
);
   reg [15:0] mem [0:15]; // word store
   reg [15:0] latchQ = 16'h0000; // captured address
   reg [15:0] drvQ = 16'h0000; // far side drive, toggles when released
   wire [15:0] adr = busMuxed ? latchQ : lowAddr;
   // wire level from both parties
   assign level = {upOe ? upOut : drvQ[15:8], loOe ? loOut : drvQ[7:0]};
   // latch, lane decode, read drive one cycle late
   always @(posedge sys_clk) begin
      if (strobe) latchQ <= {upOut, loOut};
      if (active && upOe && !strobe && !hbeN) mem[adr[4:1]][15:8] <= upOut;
      if (active && loOe && !strobe && !adr[0]) mem[adr[4:1]][7:0] <= loOut;
      drvQ <= (active && !loOe) ? mem[adr[4:1]] : ~drvQ;
   end
endmodule // ebm_mem_model
`default_nettype wire

// ### verilog/ebm_bus_pins.v
// external bus pin muxing: sequences one external cycle onto the pins
// assumes core requests are synchronous and held stable until done pulses
`timescale 1ns/100ps
`default_nettype none
`include "ebm_defines.vh"
module ebm_bus_pins #(
   parameter AW = 20,
   parameter DW = 16,
   parameter HW = 8
) (
   input wire sys_clk,
   input wire rstn,
   input wire reqValid,
   input wire reqWrite,
   input wire [AW-1:0] reqAddr,
   input wire [1:0] reqLanes,
   input wire [DW-1:0] reqWdata,
   input wire busWide,
   input wire busMuxed,
   input wire chipCfgHighEnable,
   input wire [DW-1:0] internalBus,
   input wire [DW-1:0] portOut,
   input wire [DW-1:0] portOe,
   input wire [DW-1:0] sharedIn,
   output wire [HW-1:0] sharedUpperOut,
   output wire sharedUpperOe,
   output wire [HW-1:0] sharedLowerOut,
   output wire sharedLowerOe,
   output reg [AW-17:0] upperAddrOut_q,
   output reg [15:0] lowAddrOut_q,
   output reg addrLatchStrobe_q,
   output reg highByteEnable_n_q,
   output reg busActive_q,
   output reg [DW-1:0] rdData_q,
   output reg done_q
);
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [3:0] cnt_q; // cycles left in current phase after this one
   reg [3:0] cnt_d;
   reg write_q; // latched direction
   reg wide_q; // latched width
   reg muxed_q; // latched mode
   reg cfgHbe_q; // latched pin role
   reg [1:0] lanes_q; // latched byte lanes
   reg [AW-1:0] addr_q; // address held for the whole cycle
   reg [DW-1:0] wdata_q;
   wire inAddr = (state_d == `EBM_ST_ADDR);
   wire own = (state_d == `EBM_ST_ADDR) || (state_d == `EBM_ST_DATA);
   wire [AW-1:0] addrSel = (state_q == `EBM_ST_IDLE) ? reqAddr : addr_q;
   wire muxSel = (state_q == `EBM_ST_IDLE) ? busMuxed : muxed_q;
   wire wideSel = (state_q == `EBM_ST_IDLE) ? busWide : wide_q;
   wire wrSel = (state_q == `EBM_ST_IDLE) ? reqWrite : write_q;
   wire [DW-1:0] wdSel = (state_q == `EBM_ST_IDLE) ? reqWdata : wdata_q;
   // lower lane: address in mux address phase (first of three cycles), otherwise data
   wire lowUseAddr = muxSel && inAddr;
   wire lowDrive = lowUseAddr || wrSel;
   // upper lane behaviour depends on width and mode
   reg upUseAddr;
   reg upDrive;
   reg [HW-1:0] upData;
   always @* begin
      upUseAddr = 1'b0;
      upDrive = 1'b0;
      upData = wdSel[DW-1:HW];
      if (muxSel && wideSel) begin
         upUseAddr = inAddr;
         upDrive = inAddr || wrSel;
      end else if (muxSel) begin
         upUseAddr = 1'b1;
         upDrive = 1'b1;
      end else if (wideSel) begin
         upDrive = wrSel;
      end else begin
         // internal high byte shown, always driven
         upData = internalBus[DW-1:HW];
         upDrive = 1'b1;
      end
   end
   // lower byte lane instance
   ebm_lane_drv #(.W(HW)) uLow (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .useAddr(lowUseAddr),
      .drive(lowDrive),
      .addrByte(addrSel[HW-1:0]),
      .dataByte(wdSel[HW-1:0]),
      .portByte(portOut[HW-1:0]),
      .portOe(|portOe[HW-1:0]),
      .busOwn(own),
      .laneOut_q(sharedLowerOut),
      .laneOe_q(sharedLowerOe)
   );
   // upper byte lane instance
   ebm_lane_drv #(.W(HW)) uUp (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .useAddr(upUseAddr),
      .drive(upDrive),
      .addrByte(addrSel[DW-1:HW]),
      .dataByte(upData),
      .portByte(portOut[DW-1:HW]),
      .portOe(|portOe[DW-1:HW]),
      .busOwn(own),
      .laneOut_q(sharedUpperOut),
      .laneOe_q(sharedUpperOe)
   );
   // sequencer next state
   always @* begin
      state_d = state_q;
      cnt_d = cnt_q;
      case (state_q)
         `EBM_ST_IDLE: begin
            if (reqValid) begin
               state_d = `EBM_ST_ADDR;
               cnt_d = `EBM_ADDR_CYCLES - 4'h1;
            end
         end
         `EBM_ST_ADDR: begin
            if (cnt_q == 4'h0) begin
               state_d = `EBM_ST_DATA;
               cnt_d = `EBM_DATA_CYCLES - 4'h1;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         `EBM_ST_DATA: begin
            if (cnt_q == 4'h0) begin
               state_d = `EBM_ST_END;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         default: begin
            // one idle turn so a new cycle gets a fresh strobe
            state_d = `EBM_ST_IDLE;
         end
      endcase
   end
   // high byte enable value for a new cycle
   reg hbeNext;
   always @* begin
      hbeNext = 1'b1;
      if (!busWide) begin
         hbeNext = 1'b1;
      end else if (chipCfgHighEnable) begin
         // low when upper lane takes part; address bit zero then tells high-only
         hbeNext = ~reqLanes[1];
      end else begin
         // write strobe role: low only for writes on upper lane
         hbeNext = ~(reqWrite && reqLanes[1]);
      end
   end
   // sequencer and pin registers
   always @(posedge sys_clk) begin
      if (!rstn) begin
         state_q <= `EBM_ST_IDLE;
         cnt_q <= 4'h0;
         write_q <= 1'b0;
         wide_q <= 1'b0;
         muxed_q <= 1'b0;
         cfgHbe_q <= 1'b1;
         lanes_q <= 2'h0;
         addr_q <= {AW{1'b0}};
         wdata_q <= {DW{1'b0}};
         upperAddrOut_q <= {(AW-16){1'b0}};
         lowAddrOut_q <= 16'h0000;
         addrLatchStrobe_q <= 1'b0;
         highByteEnable_n_q <= 1'b1;
         busActive_q <= 1'b0;
         rdData_q <= {DW{1'b0}};
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         done_q <= 1'b0;
         // strobe high only in first cycle of an external cycle
         addrLatchStrobe_q <= (state_q == `EBM_ST_IDLE) && reqValid;
         busActive_q <= own;
         if (state_q == `EBM_ST_IDLE && reqValid) begin
            write_q <= reqWrite;
            wide_q <= busWide;
            muxed_q <= busMuxed;
            cfgHbe_q <= chipCfgHighEnable;
            lanes_q <= reqLanes;
            addr_q <= reqAddr;
            wdata_q <= reqWdata;
            // address pins valid with the strobe, held to cycle end
            lowAddrOut_q <= reqAddr[15:0];
            upperAddrOut_q <= reqAddr[AW-1:16];
            if (busWide && chipCfgHighEnable && reqLanes == `EBM_LANE_LOW) begin
               highByteEnable_n_q <= 1'b1;
            end else begin
               highByteEnable_n_q <= hbeNext;
            end
         end
         if (state_q == `EBM_ST_DATA && cnt_q == 4'h0) begin
            // sample read data at the last data cycle
            if (!write_q) begin
               rdData_q <= sharedIn;
            end
            done_q <= 1'b1;
         end
         if (state_d == `EBM_ST_END || state_d == `EBM_ST_IDLE) begin
            highByteEnable_n_q <= 1'b1; // deassert between cycles
         end
      end
   end
endmodule // ebm_bus_pins
`default_nettype wire

// ### verilog/ebm_lane_drv.v
// one byte lane of the shared address/data lines
// assumes the top module decides phase and enable per cycle
`timescale 1ns/100ps
`default_nettype none
module ebm_lane_drv #(
   parameter W = 8
) (
   input wire sys_clk,
   input wire rstn,
   input wire useAddr,
   input wire drive,
   input wire [W-1:0] addrByte,
   input wire [W-1:0] dataByte,
   input wire [W-1:0] portByte,
   input wire portOe,
   input wire busOwn,
   output reg [W-1:0] laneOut_q,
   output reg laneOe_q
);
   // registered mux: bus owns lane during a cycle, else port function
   always @(posedge sys_clk) begin
      if (!rstn) begin
         laneOut_q <= {W{1'b0}};
         laneOe_q <= 1'b0;
      end else if (busOwn) begin
         laneOut_q <= useAddr ? addrByte : dataByte;
         laneOe_q <= drive;
      end else begin
         // general purpose port restored between cycles
         laneOut_q <= portByte;
         laneOe_q <= portOe;
      end
   end
endmodule // ebm_lane_drv
`default_nettype wire
